/* File: rtl/wdc_pkg.sv */
// package: register map, field layout and timing constants of the watchdog control block
package wdc_pkg;

    localparam int unsigned CLK_HZ      = 50_000_000;
    localparam int unsigned OSC_HZ      = 128_000;
    // oscillator period rounded down to whole system clocks
    localparam int unsigned OSC_DIV     = CLK_HZ / OSC_HZ;
    localparam int unsigned CE_CYCLES   = 4;

    localparam logic [3:0] ADDR_CTRL    = 4'h0;
    localparam logic [3:0] ADDR_CAUSE   = 4'h1;
    localparam logic [3:0] ADDR_CPU     = 4'h2;
    localparam logic [3:0] ADDR_ISTAT   = 4'h3;
    localparam logic [3:0] ADDR_IEN     = 4'h4;
    localparam logic [3:0] ADDR_ICLR    = 4'h5;

    localparam int unsigned BIT_IFLAG   = 7;
    localparam int unsigned BIT_IEN     = 6;
    localparam int unsigned BIT_TSEL3   = 5;
    localparam int unsigned BIT_CE      = 4;
    localparam int unsigned BIT_RSTEN   = 3;
    localparam int unsigned BIT_RSTFLAG = 3;
    localparam int unsigned BIT_GIE     = 0;
    localparam int unsigned BIT_VECTOR  = 1;
    localparam int unsigned BIT_RESTART = 2;
    localparam int unsigned EV_TIMEOUT  = 0;
    localparam int unsigned EV_SYSRST   = 1;

    localparam logic [3:0]  TSEL_MAX    = 4'h9;
    localparam int unsigned CNT_W       = 21;
    localparam logic [7:0]  CTRL_RESET  = 8'h00;

    typedef enum logic [1:0] {WDC_STOPPED, WDC_IRQ, WDC_RESET, WDC_IRQ_RESET} wdc_mode_t;

    typedef struct packed {
        logic [3:0]  address;
        logic        read;
        logic        write;
        logic [31:0] writedata;
    } wdc_avm_req_t;

    typedef struct packed {
        logic [31:0] readdata;
        logic        waitrequest;
    } wdc_avm_rsp_t;

endpackage

/* File: rtl/wdc_osc_counter.sv */
// module: watchdog oscillator tick generator and time-out counter
`timescale 1ns/100ps
module wdc_osc_counter
(
    input  wire logic       clk,
    input  wire logic       srst,
    input  wire logic       ce,
    input  wire logic       run,
    input  wire logic       restart,
    input  wire logic [3:0] timeoutSelect,
    output logic            timeoutPulse
);
    typedef struct packed {
        logic [15:0]               div;
        logic [wdc_pkg::CNT_W-1:0] cnt;
        logic                      tmo;
    } wdc_cnt_state_t;

    wdc_cnt_state_t st;
    wdc_cnt_state_t next_st;

    // 2048 << code oscillator cycles
    function automatic logic [wdc_pkg::CNT_W-1:0] limit(input logic [3:0] code);
        limit = wdc_pkg::CNT_W'(2048) << code;
    endfunction

    always_comb
    begin
        next_st     = st;
        next_st.tmo = 1'b0;
        if (!run || restart)
        begin
            next_st.div = '0;
            next_st.cnt = '0;
        end
        else if (st.div == 16'(wdc_pkg::OSC_DIV - 1))
        begin
            next_st.div = '0;
            if (st.cnt + 1'b1 >= limit(timeoutSelect))
            begin
                next_st.cnt = '0;
                next_st.tmo = 1'b1;
            end
            else
            begin
                next_st.cnt = st.cnt + 1'b1;
            end
        end
        else
        begin
            next_st.div = st.div + 1'b1;
        end
    end

    always_ff @(posedge clk)
    begin
        if (srst)
            st <= '0;
        else if (ce)
            st <= next_st;
    end

    assign timeoutPulse = st.tmo;
endmodule

/* File: rtl/wdc_watchdog_ctrl.sv */
// module: watchdog mode, protection and interrupt control with an Avalon-MM register slave
// Contract
// - watchdog interrupt taken only when irq enable and global enable both set
// - irq enable set, reset enable clear: interrupt on every time-out
// - both enables set: first time-out sets irq flag, no reset
// - vector entry clears irq enable and irq flag by hardware
// - combined mode, flag still pending at next time-out: system reset
// - without fuse, reset/irq enables pick stopped, irq, reset, irq-then-reset
// - clearing reset enable or changing timeout select needs change enable set
// - change enable clears itself four clocks after being written one
// - reset-occurred flag forces reset enable to one until flag cleared
// - timeout codes 0..9 give 2048 doubling to 1048576 cycles; rest reserved
// - timeout select msb at bit 5, low bits at bits 2..0
// - always-on fuse forces reset mode, reset enable 1, irq enable 0
// - protected values written in one write within four clocks after arming
// - irq flag cleared by writing one to it or on vector entry
// - counts 128 kHz oscillator cycles, restart instruction restarts count
//
// The Avalon-MM register port and the placing of the registers were left to the implementer.
`timescale 1ns/100ps
module wdc_watchdog_ctrl
(
    input  wire logic                  clk,
    input  wire logic                  srst,
    input  wire logic                  ce,
    input  wire wdc_pkg::wdc_avm_req_t avm,
    output wdc_pkg::wdc_avm_rsp_t      avmRsp,
    input  wire logic                  wdAlwaysOnFuse,
    output logic                       wdIrq,
    output logic                       sysResetReq,
    output logic                       irqOut
);
    ////////////////////////////////////////////////////////////////////////////
    typedef struct packed {
        logic       irqFlag;
        logic       irqEnable;
        logic       resetEnable;
        logic [3:0] tsel;
        logic       changeEnable;
        logic [2:0] ceCount;
        logic       resetOccurred;
        logic       globalIrqEnable;
        logic       sysReset;
        logic [1:0] evStatus;
        logic [1:0] evEnable;
        logic [31:0] rdata;
        logic       ack;
    } wdc_state_t;

    wdc_state_t st;
    wdc_state_t next_st;
    logic       timeoutPulse;
    logic       effReset;
    logic       effIrqEn;
    logic       wrAccept;
    logic       rdAccept;
    logic       vectorEntry;
    logic       restartReq;
    logic [7:0] wd;
    wdc_pkg::wdc_mode_t mode;

    function automatic logic [7:0] ctrl_image(input wdc_state_t s, input logic rst, input logic ien);
        ctrl_image = wdc_pkg::CTRL_RESET;
        ctrl_image[wdc_pkg::BIT_IFLAG] = s.irqFlag;
        ctrl_image[wdc_pkg::BIT_IEN]   = ien;
        ctrl_image[wdc_pkg::BIT_TSEL3] = s.tsel[3];
        ctrl_image[wdc_pkg::BIT_CE]    = s.changeEnable;
        ctrl_image[wdc_pkg::BIT_RSTEN] = rst;
        ctrl_image[2:0]                = s.tsel[2:0];
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // one wait cycle per access: read data are loaded in it, so they stand at the accepting edge
    assign wrAccept    = avm.write && st.ack;
    assign rdAccept    = avm.read && !st.ack;
    assign wd          = avm.writedata[7:0];
    assign vectorEntry = wrAccept && avm.address == wdc_pkg::ADDR_CPU && wd[wdc_pkg::BIT_VECTOR];
    assign restartReq  = wrAccept && avm.address == wdc_pkg::ADDR_CPU && wd[wdc_pkg::BIT_RESTART];

    assign effReset = wdAlwaysOnFuse || st.resetEnable || st.resetOccurred;
    assign effIrqEn = !wdAlwaysOnFuse && st.irqEnable;

    always_comb
    begin
        unique case ({effReset, effIrqEn})
            2'b00: mode = wdc_pkg::WDC_STOPPED;
            2'b01: mode = wdc_pkg::WDC_IRQ;
            2'b10: mode = wdc_pkg::WDC_RESET;
            2'b11: mode = wdc_pkg::WDC_IRQ_RESET;
        endcase
    end

    wdc_osc_counter u_counter
    (
        .clk          (clk),
        .srst         (srst),
        .ce           (ce),
        .run          (mode != wdc_pkg::WDC_STOPPED),
        .restart      (restartReq),
        .timeoutSelect(st.tsel),
        .timeoutPulse (timeoutPulse)
    );

    ////////////////////////////////////////////////////////////////////////////
    always_comb
    begin
        next_st          = st;
        next_st.sysReset = 1'b0;
        next_st.ack      = (avm.read || avm.write) && !st.ack;

        if (st.changeEnable)
        begin
            if (st.ceCount == 3'(wdc_pkg::CE_CYCLES - 1))
                next_st.changeEnable = 1'b0;
            next_st.ceCount = st.ceCount + 1'b1;
        end

        if (wrAccept)
        begin
            unique case (avm.address)
                wdc_pkg::ADDR_CTRL:
                begin
                    if (wd[wdc_pkg::BIT_IFLAG])
                        next_st.irqFlag = 1'b0;
                    next_st.irqEnable = wd[wdc_pkg::BIT_IEN];
                    if (st.changeEnable)
                    begin
                        next_st.resetEnable = wd[wdc_pkg::BIT_RSTEN];
                        next_st.tsel = {wd[wdc_pkg::BIT_TSEL3], wd[2:0]};
                    end
                    else if (wd[wdc_pkg::BIT_RSTEN])
                        next_st.resetEnable = 1'b1;
                    if (wd[wdc_pkg::BIT_CE])
                    begin
                        next_st.changeEnable = 1'b1;
                        next_st.ceCount      = '0;
                    end
                end
                wdc_pkg::ADDR_CAUSE: next_st.resetOccurred = wd[wdc_pkg::BIT_RSTFLAG];
                wdc_pkg::ADDR_CPU:
                begin
                    next_st.globalIrqEnable = wd[wdc_pkg::BIT_GIE];
                    if (wd[wdc_pkg::BIT_VECTOR])
                    begin
                        next_st.irqFlag   = 1'b0;
                        next_st.irqEnable = 1'b0;
                    end
                end
                wdc_pkg::ADDR_IEN:   next_st.evEnable = wd[1:0];
                wdc_pkg::ADDR_ICLR:  next_st.evStatus = st.evStatus & ~wd[1:0];
                default:             ;
            endcase
        end

        if (timeoutPulse)
        begin
            next_st.evStatus[wdc_pkg::EV_TIMEOUT] = 1'b1;
            unique case (mode)
                wdc_pkg::WDC_IRQ:       next_st.irqFlag = 1'b1;
                wdc_pkg::WDC_RESET:     next_st.sysReset = 1'b1;
                wdc_pkg::WDC_IRQ_RESET:
                    if (st.irqFlag)
                        next_st.sysReset = 1'b1;
                    else
                        next_st.irqFlag = 1'b1;
                default: ;
            endcase
            if (next_st.sysReset)
            begin
                next_st.resetOccurred = 1'b1;
                next_st.evStatus[wdc_pkg::EV_SYSRST] = 1'b1;
            end
        end

        next_st.rdata = '0;
        if (rdAccept)
        begin
            unique case (avm.address)
                wdc_pkg::ADDR_CTRL:  next_st.rdata[7:0] = ctrl_image(st, effReset, effIrqEn);
                wdc_pkg::ADDR_CAUSE: next_st.rdata[wdc_pkg::BIT_RSTFLAG] = st.resetOccurred;
                wdc_pkg::ADDR_CPU:   next_st.rdata[wdc_pkg::BIT_GIE] = st.globalIrqEnable;
                wdc_pkg::ADDR_ISTAT: next_st.rdata[1:0] = st.evStatus;
                wdc_pkg::ADDR_IEN:   next_st.rdata[1:0] = st.evEnable;
                default:             next_st.rdata = '0;
            endcase
        end
        else
            next_st.rdata = st.rdata;
        if (wdAlwaysOnFuse)
        begin
            next_st.resetEnable = 1'b1;
            next_st.irqEnable   = 1'b0;
        end
        if (next_st.resetOccurred)
            next_st.resetEnable = 1'b1;
    end

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            st      <= '0;
        end
        else if (ce)
            st <= next_st;
    end

    assign avmRsp.readdata    = st.rdata;
    assign avmRsp.waitrequest = (avm.read || avm.write) && !st.ack;
    assign wdIrq       = st.irqFlag && effIrqEn && st.globalIrqEnable;
    assign sysResetReq = st.sysReset;
    assign irqOut      = |(st.evStatus & st.evEnable);

    ////////////////////////////////////////////////////////////////////////////
    chk_ce_autoclear: assert property (@(posedge clk) disable iff (srst)
        $rose(st.changeEnable) ##0 ce [*5] |-> !st.changeEnable)
        else $error("change enable not cleared after four cycles");
    chk_irq_gating: assert property (@(posedge clk) disable iff (srst)
        wdIrq |-> st.globalIrqEnable && st.irqEnable && st.irqFlag)
        else $error("irq without both enables");
    chk_fuse_lock: assert property (@(posedge clk) disable iff (srst)
        wdAlwaysOnFuse && $past(wdAlwaysOnFuse) |-> st.resetEnable && !st.irqEnable)
        else $error("fuse does not lock enables");
    chk_flag_force: assert property (@(posedge clk) disable iff (srst)
        st.resetOccurred |-> st.resetEnable)
        else $error("reset enable clear while flag set");
    chk_combined_first: assert property (@(posedge clk) disable iff (srst)
        ce && timeoutPulse && mode == wdc_pkg::WDC_IRQ_RESET && !st.irqFlag |=> st.irqFlag && !sysResetReq)
        else $error("first combined timeout did not set flag");
    chk_combined_second: assert property (@(posedge clk) disable iff (srst)
        ce && timeoutPulse && mode == wdc_pkg::WDC_IRQ_RESET && st.irqFlag |=> sysResetReq)
        else $error("second combined timeout did not reset");
    chk_irq_mode: assert property (@(posedge clk) disable iff (srst)
        ce && timeoutPulse && mode == wdc_pkg::WDC_IRQ |=> st.irqFlag && !sysResetReq)
        else $error("interrupt mode timeout missed");
    chk_vector_clear: assert property (@(posedge clk) disable iff (srst)
        ce && vectorEntry && !timeoutPulse |=> !st.irqFlag && !st.irqEnable)
        else $error("vector did not clear flag and enable");
    chk_protect: assert property (@(posedge clk) disable iff (srst)
        ce && !st.changeEnable && !st.resetOccurred |=> $stable(st.tsel) && (st.resetEnable || !$past(st.resetEnable)))
        else $error("protected field changed without change enable");
    cov_combined: cover property (@(posedge clk) mode == wdc_pkg::WDC_IRQ_RESET && sysResetReq);
    cov_irq: cover property (@(posedge clk) wdIrq);
    cov_unlock: cover property (@(posedge clk) $fell(st.changeEnable));
endmodule

/* File: test/wdc_watchdog_ctrl_tb.sv */
// testbench: register-level scenarios for the watchdog control block
`timescale 1ns/100ps
`define CHK(nm, exp, got) begin checks++; if ((got) !== (exp)) begin errTotal++; \
    $display("CHECK FAILED %s expected %h seen %h", nm, exp, got); end end
module testbench;
    logic                  clk;
    logic                  srst;
    logic                  fuse;
    wdc_pkg::wdc_avm_req_t avm;
    wdc_pkg::wdc_avm_rsp_t avmRsp;
    logic                  wdIrq;
    logic                  sysResetReq;
    logic                  irqOut;
    int                    errTotal;
    int                    checks;
    logic [7:0]            rd;

    wdc_watchdog_ctrl wdc_watchdog_ctrl_i
    (
        .clk            (clk),
        .srst           (srst),
        .ce             (1'b1),
        .avm            (avm),
        .avmRsp         (avmRsp),
        .wdAlwaysOnFuse (fuse),
        .wdIrq          (wdIrq),
        .sysResetReq    (sysResetReq),
        .irqOut         (irqOut)
    );

    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // waitrequest and readdata sampled at the rising edge, before the slave's registers move
    task automatic bus_xfer(input logic [3:0] a, input logic wr, input logic [7:0] d);
        int n;
        avm <= '{a, ~wr, wr, {24'h00_0000, d}};
        n = 0;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (avmRsp.waitrequest !== 1'b0 && n < 50);
        rd = avmRsp.readdata[7:0];
        if (n >= 50)
        begin
            errTotal++;
            $display("CHECK FAILED waitrequest expected 0 seen %b", avmRsp.waitrequest);
        end
        avm.read  <= 1'b0;
        avm.write <= 1'b0;
        // one idle edge so the next request never reassigns in this time step
        @(posedge clk);
    endtask

    // read data taken at the accepting edge inside bus_xfer
    task automatic chk_reg(input logic [3:0] a, input logic [7:0] exp, input string nm);
        bus_xfer(a, 1'b0, 8'h00);
        `CHK(nm, exp, rd)
    endtask

    task automatic arm_and_write(input logic [7:0] d);
        bus_xfer(wdc_pkg::ADDR_CTRL, 1'b1, 8'h18);
        bus_xfer(wdc_pkg::ADDR_CTRL, 1'b1, d);
        repeat (8) @(posedge clk);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_reset_values();
        @(posedge clk);
        srst <= 1'b1;
        repeat (4) @(posedge clk);
        srst <= 1'b0;
        chk_reg(wdc_pkg::ADDR_CTRL, 8'h00, "ctrl");
        chk_reg(wdc_pkg::ADDR_CAUSE, 8'h00, "cause");
        chk_reg(wdc_pkg::ADDR_ISTAT, 8'h00, "istat");
        chk_reg(4'hF, 8'h00, "unmapped");
        `CHK("outputs", 3'b000, {wdIrq, sysResetReq, irqOut})
    endtask

    task automatic t_protect();
        // flag write-one on a clear flag, tsel without change enable: only reset enable lands
        bus_xfer(wdc_pkg::ADDR_CTRL, 1'b1, 8'h8D);
        chk_reg(wdc_pkg::ADDR_CTRL, 8'h08, "ctrl no ce");
        bus_xfer(wdc_pkg::ADDR_CTRL, 1'b1, 8'h18);
        chk_reg(wdc_pkg::ADDR_CTRL, 8'h18, "ce set");
        repeat (8) @(posedge clk);
        bus_xfer(wdc_pkg::ADDR_CTRL, 1'b1, 8'h00);
        chk_reg(wdc_pkg::ADDR_CTRL, 8'h08, "ce expired");
        arm_and_write(8'h29);
        chk_reg(wdc_pkg::ADDR_CTRL, 8'h29, "tsel split");
        arm_and_write(8'h00);
        chk_reg(wdc_pkg::ADDR_CTRL, 8'h00, "stopped");
    endtask

    task automatic t_reset_flag();
        bus_xfer(wdc_pkg::ADDR_CAUSE, 1'b1, 8'h08);
        chk_reg(wdc_pkg::ADDR_CTRL, 8'h08, "forced rsten");
        arm_and_write(8'h00);
        chk_reg(wdc_pkg::ADDR_CTRL, 8'h08, "clear refused");
        bus_xfer(wdc_pkg::ADDR_CAUSE, 1'b1, 8'h00);
        arm_and_write(8'h00);
        chk_reg(wdc_pkg::ADDR_CTRL, 8'h00, "clear after flag");
    endtask

    task automatic t_fuse();
        @(posedge clk);
        fuse <= 1'b1;
        bus_xfer(wdc_pkg::ADDR_CTRL, 1'b1, 8'h40);
        chk_reg(wdc_pkg::ADDR_CTRL, 8'h08, "fuse lock");
        arm_and_write(8'h40);
        chk_reg(wdc_pkg::ADDR_CTRL, 8'h08, "fuse timed");
        @(posedge clk);
        fuse <= 1'b0;
    endtask

    task automatic t_vector();
        bus_xfer(wdc_pkg::ADDR_CPU, 1'b1, 8'h01);
        bus_xfer(wdc_pkg::ADDR_CTRL, 1'b1, 8'h40);
        chk_reg(wdc_pkg::ADDR_CTRL, 8'h40, "irq mode");
        `CHK("wdIrq no flag", 1'b0, wdIrq)
        bus_xfer(wdc_pkg::ADDR_CPU, 1'b1, 8'h03);
        chk_reg(wdc_pkg::ADDR_CTRL, 8'h00, "vector clears");
        bus_xfer(wdc_pkg::ADDR_CPU, 1'b1, 8'h05);
        chk_reg(wdc_pkg::ADDR_CTRL, 8'h00, "restart");
    endtask

    task automatic t_events();
        bus_xfer(wdc_pkg::ADDR_IEN, 1'b1, 8'h03);
        chk_reg(wdc_pkg::ADDR_IEN, 8'h03, "ev enable");
        // status is read-only: writes must not set it
        bus_xfer(wdc_pkg::ADDR_ISTAT, 1'b1, 8'hFF);
        chk_reg(wdc_pkg::ADDR_ISTAT, 8'h00, "ev status");
        bus_xfer(wdc_pkg::ADDR_ICLR, 1'b1, 8'h03);
        `CHK("irqOut", 1'b0, irqOut)
        bus_xfer(wdc_pkg::ADDR_IEN, 1'b1, 8'h00);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", checks, errTotal);
        if (errTotal == 0 && checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // a full timeout is ~800k cycles, so time-out driven modes are not reached here
    initial
    begin
        repeat (20000) @(posedge clk);
        errTotal++;
        summarize();
    end

    initial
    begin
        errTotal = 0;
        checks   = 0;
        srst     = 1'b1;
        fuse     = 1'b0;
        avm      = '0;
        t_reset_values();
        t_protect();
        t_reset_flag();
        t_vector();
        t_events();
        t_fuse();
        t_reset_values();
        summarize();
    end
endmodule
